// [lcdsd_defines.svh]
// constants for the lcd segment shift and latch driver
// What this block does
// - the first serial input feeds a 20-bit shift register holding display bits 1 to 20.
// - the second serial input feeds a separate 20-bit shift register holding bits 21 to 40.
// - both registers advance one place on each falling edge of the shift clock.
// - the middle chain output is the last stage of the first register, 20 shifts late.
// - the end chain output is the last stage of the second register, 20 shifts late.
// - wiring the middle chain output to the second input makes one 40-bit register.
// - the end chain output may feed the first input of a following device.
// - while the latch strobe is high the latch passes the register contents through.
// - while the latch strobe is low the latch and the outputs hold their data.
// - each of the 40 segment outputs is driven by its own latch bit only.
// - a latched high bit gives the lowest level with frame high, the top level with it low.
// - a latched low bit gives one third with frame high, two thirds with it low.
`ifndef LCDSD_DEFINES_SVH
`define LCDSD_DEFINES_SVH

`define LCDSD_HALF_W       20
`define LCDSD_SEG_N        40
`define LCDSD_CODE_W       2
`define LCDSD_SR_RST       20'h00000
`define LCDSD_LATCH_RST    40'h00_0000_0000
`define LCDSD_SEG_RST      80'h0000_0000_0000_0000_0000

`endif

// [lcdsd_pkg.sv]
// types for the lcd segment shift and latch driver
package lcdsd_pkg;

    typedef enum logic [1:0] {
        LCDSD_BIAS_TOP        = 2'h0,
        LCDSD_BIAS_TWO_THIRDS = 2'h1,
        LCDSD_BIAS_ONE_THIRD  = 2'h2,
        LCDSD_BIAS_LOWEST     = 2'h3
    } lcdsd_bias_t;

    typedef logic [39:0] lcdsd_frame_t;

endpackage

// [lcdsd_stream_if.sv]
// valid/ready word channel between the driver's own modules
`timescale 1ns/1ps
`default_nettype none
interface lcdsd_stream_if #(
    parameter int W = 40
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [lcdsd_shreg.sv]
// one serial-in shift register with a chain output on its last stage
`timescale 1ns/1ps
`default_nettype none
module lcdsd_shreg
    import lcdsd_pkg::*;
#(
    parameter int W = 20
)(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic         shift_en,
    input  wire logic         din,
    output logic [W-1:0] q,
    output logic         chain
);
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // stage 0 takes the newest bit
    assign nxt_q = {q_ff[W-2:0], din};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= '0;
        end else if (ce && shift_en) begin
            q_ff <= nxt_q;
        end
    end

    assign q     = q_ff;
    assign chain = q_ff[W-1];
endmodule // lcdsd_shreg
`default_nettype wire

// [lcdsd_fifo2.sv]
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module lcdsd_fifo2
    import lcdsd_pkg::*;
#(
    parameter int W = 40
)(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    lcdsd_stream_if.snk in_if,
    lcdsd_stream_if.src out_if
);
    logic         v0_ff;
    logic         v1_ff;
    logic [W-1:0] d0_ff;
    logic [W-1:0] d1_ff;
    wire          push = ce & in_if.valid & ~v1_ff;
    wire          pop  = ce & out_if.ready & v0_ff;
    wire          nxt_v0 = v0_ff ? (~pop | v1_ff | push) : push;
    wire          nxt_v1 = (v1_ff & ~pop) | (v0_ff & push & ~pop);
    wire          ld0_from_d1 = pop & v1_ff;
    wire          ld0_from_in = push & (~v0_ff | (pop & ~v1_ff));
    wire          ld1_from_in = push & v0_ff & ~pop;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            v0_ff <= 1'b0;
            v1_ff <= 1'b0;
        end else if (ce) begin
            v0_ff <= nxt_v0;
            v1_ff <= nxt_v1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d0_ff <= '0;
            d1_ff <= '0;
        end else begin
            if (ld0_from_d1) begin
                d0_ff <= d1_ff;
            end else if (ld0_from_in) begin
                d0_ff <= in_if.data;
            end
            if (ld1_from_in) begin
                d1_ff <= in_if.data;
            end
        end
    end

    assign in_if.ready  = ~v1_ff;
    assign out_if.valid = v0_ff;
    assign out_if.data  = d0_ff;

    property p_full_holds;
        @(posedge clk) disable iff (!nrst)
        (ce && v1_ff && !out_if.ready) |=> (v1_ff && $stable(d0_ff) && $stable(d1_ff));
    endproperty
    a_full_holds: assert property (p_full_holds) else $error("full buffer lost a word");

    property p_order;
        @(posedge clk) disable iff (!nrst)
        (pop && v1_ff) |=> (v0_ff && d0_ff == $past(d1_ff));
    endproperty
    a_order: assert property (p_order) else $error("buffer words out of order");
endmodule // lcdsd_fifo2
`default_nettype wire

// [lcdsd_driver.sv]
// top of the lcd segment driver: two shift registers, latch, bias coder, snapshot stream
`timescale 1ns/1ps
`default_nettype none
`include "lcdsd_defines.svh"
module lcdsd_driver
    import lcdsd_pkg::*;
#(
    parameter int HALF_W = `LCDSD_HALF_W,
    parameter int SEG_N  = `LCDSD_SEG_N
)(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic                    shift_clock,
    input  wire logic                    serial_in_first_half,
    input  wire logic                    serial_in_second_half,
    input  wire logic                    latch_strobe,
    input  wire logic                    frame_alternate,
    output logic                         chain_mid_out,
    output logic                         chain_end_out,
    output logic [2*SEG_N-1:0]           segment_bias,
    output logic                         snap_valid,
    input  wire logic                    snap_ready,
    output logic [SEG_N-1:0]             snap_data,
    output logic                         snap_overrun
);
    // shift clock edge detection on the sampled pin
    logic                shift_clock_ff;
    logic                latch_strobe_ff;
    wire                 shift_fall = shift_clock_ff & ~shift_clock;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_clock_ff  <= 1'b0;
            latch_strobe_ff <= 1'b0;
        end else if (ce) begin
            shift_clock_ff  <= shift_clock;
            latch_strobe_ff <= latch_strobe;
        end
    end

    // two independent halves; chaining is done by outside wiring
    logic [HALF_W-1:0]   sr_first_q;
    logic [HALF_W-1:0]   sr_second_q;

    lcdsd_shreg #(
        .W (HALF_W)
    ) u_sr_first (
        .clk      (clk),
        .nrst     (nrst),
        .ce       (ce),
        .shift_en (shift_fall),
        .din      (serial_in_first_half),
        .q        (sr_first_q),
        .chain    (chain_mid_out)
    );

    lcdsd_shreg #(
        .W (HALF_W)
    ) u_sr_second (
        .clk      (clk),
        .nrst     (nrst),
        .ce       (ce),
        .shift_en (shift_fall),
        .din      (serial_in_second_half),
        .q        (sr_second_q),
        .chain    (chain_end_out)
    );

    // segment n takes the bit shifted in n-th, i.e. the oldest stage first
    logic [SEG_N-1:0]    shift_all;

    genvar gi;
    generate
        for (gi = 0; gi < HALF_W; gi++) begin : g_map
            assign shift_all[gi]        = sr_first_q[HALF_W-1-gi];
            assign shift_all[HALF_W+gi] = sr_second_q[HALF_W-1-gi];
        end
    endgenerate

    // transparent while the strobe is high, holding while it is low
    logic [SEG_N-1:0]    latch_ff;
    wire                 latch_open = ce & latch_strobe;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_ff <= `LCDSD_LATCH_RST;
        end else if (latch_open) begin
            latch_ff <= shift_all;
        end
    end

    // bias level coder, one latch bit in and a two-bit level out per segment
    logic [2*SEG_N-1:0]  nxt_segment_bias;
    logic [2*SEG_N-1:0]  segment_bias_ff;

    generate
        for (gi = 0; gi < SEG_N; gi++) begin : g_bias
            wire         sel_bit = latch_ff[gi];
            wire [1:0]   sel_code = frame_alternate ? LCDSD_BIAS_LOWEST
                                                    : LCDSD_BIAS_TOP;
            wire [1:0]   non_code = frame_alternate ? LCDSD_BIAS_ONE_THIRD
                                                    : LCDSD_BIAS_TWO_THIRDS;
            assign nxt_segment_bias[2*gi +: 2] = sel_bit ? sel_code : non_code;
        end
    endgenerate

    // frame_alternate may carry the common signal of a static panel as well
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            segment_bias_ff <= `LCDSD_SEG_RST;
        end else if (ce) begin
            segment_bias_ff <= nxt_segment_bias;
        end
    end

    assign segment_bias = segment_bias_ff;

    // snapshot of the held latch each time the strobe closes
    wire                 snap_evt = ce & latch_strobe_ff & ~latch_strobe;
    logic                pend_ff;
    logic [SEG_N-1:0]    pend_data_ff;
    logic                overrun_ff;

    lcdsd_stream_if #(.W(SEG_N)) buf_in_if ();
    lcdsd_stream_if #(.W(SEG_N)) buf_out_if ();

    assign buf_in_if.valid = pend_ff;
    assign buf_in_if.data  = pend_data_ff;

    wire                 pend_taken = ce & pend_ff & buf_in_if.ready;
    wire                 pend_lost  = snap_evt & pend_ff & ~buf_in_if.ready;

    // a waiting snapshot stalls here until the buffer takes it or a newer snapshot overwrites it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_ff      <= 1'b0;
            pend_data_ff <= `LCDSD_LATCH_RST;
        end else if (snap_evt) begin
            pend_ff      <= 1'b1;
            pend_data_ff <= latch_ff;
        end else if (pend_taken) begin
            pend_ff      <= 1'b0;
        end
    end

    // sticky until reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            overrun_ff <= 1'b0;
        end else if (pend_lost) begin
            overrun_ff <= 1'b1;
        end
    end

    lcdsd_fifo2 #(
        .W (SEG_N)
    ) u_buf (
        .clk    (clk),
        .nrst   (nrst),
        .ce     (ce),
        .in_if  (buf_in_if),
        .out_if (buf_out_if)
    );

    assign buf_out_if.ready = snap_ready;
    assign snap_valid       = buf_out_if.valid;
    assign snap_data        = buf_out_if.data;
    assign snap_overrun     = overrun_ff;

    // checks
    property p_first_shift_in;
        @(posedge clk) disable iff (!nrst)
        (ce && shift_fall) |=> (sr_first_q[0] == $past(serial_in_first_half)
                                && sr_first_q[HALF_W-1:1] == $past(sr_first_q[HALF_W-2:0]));
    endproperty
    a_first_shift_in: assert property (p_first_shift_in) else $error("first half shift wrong");

    property p_second_shift_in;
        @(posedge clk) disable iff (!nrst)
        (ce && shift_fall) |=> (sr_second_q[0] == $past(serial_in_second_half)
                                && sr_second_q[HALF_W-1:1] == $past(sr_second_q[HALF_W-2:0]));
    endproperty
    a_second_shift_in: assert property (p_second_shift_in) else $error("second half shift wrong");

    property p_no_edge_no_shift;
        @(posedge clk) disable iff (!nrst)
        !(ce && shift_fall) |=> ($stable(sr_first_q) && $stable(sr_second_q));
    endproperty
    a_no_edge_no_shift: assert property (p_no_edge_no_shift) else $error("shift without edge");

    property p_rise_no_shift;
        @(posedge clk) disable iff (!nrst)
        (ce && !shift_clock_ff && shift_clock) |=> $stable(sr_first_q);
    endproperty
    a_rise_no_shift: assert property (p_rise_no_shift) else $error("shifted on rising edge");

    property p_mid_chain;
        @(posedge clk) disable iff (!nrst)
        (ce && shift_fall) |=> (chain_mid_out == $past(sr_first_q[HALF_W-2]));
    endproperty
    a_mid_chain: assert property (p_mid_chain) else $error("middle chain output wrong");

    property p_end_chain;
        @(posedge clk) disable iff (!nrst)
        (ce && shift_fall) |=> (chain_end_out == $past(sr_second_q[HALF_W-2]));
    endproperty
    a_end_chain: assert property (p_end_chain) else $error("end chain output wrong");

    property p_latch_pass;
        @(posedge clk) disable iff (!nrst)
        (ce && latch_strobe) |=> (latch_ff[0] == $past(sr_first_q[HALF_W-1])
                                  && latch_ff[SEG_N-1] == $past(sr_second_q[0]));
    endproperty
    a_latch_pass: assert property (p_latch_pass) else $error("latch not transparent");

    property p_latch_hold;
        @(posedge clk) disable iff (!nrst)
        (!latch_strobe || !ce) |=> $stable(latch_ff);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved while closed");

    property p_outputs_hold;
        @(posedge clk) disable iff (!nrst)
        (ce && !latch_strobe && $stable(frame_alternate)) ##1
        (ce && !latch_strobe && $stable(frame_alternate)) |=> $stable(segment_bias);
    endproperty
    a_outputs_hold: assert property (p_outputs_hold) else $error("outputs moved while held");

    property p_seg_first;
        @(posedge clk) disable iff (!nrst)
        ce |=> (segment_bias[1:0] == ($past(latch_ff[0])
                ? ($past(frame_alternate) ? 2'h3 : 2'h0)
                : ($past(frame_alternate) ? 2'h2 : 2'h1)));
    endproperty
    a_seg_first: assert property (p_seg_first) else $error("segment 1 level wrong");

    property p_seg_last;
        @(posedge clk) disable iff (!nrst)
        (ce && !latch_ff[SEG_N-1]) |=>
        (segment_bias[2*SEG_N-1 -: 2] == ($past(frame_alternate) ? 2'h2 : 2'h1));
    endproperty
    a_seg_last: assert property (p_seg_last) else $error("segment 40 level wrong");

    property p_seg_own_bit;
        @(posedge clk) disable iff (!nrst)
        (ce && $stable(frame_alternate) && latch_ff[0] == $past(latch_ff[0])
         && latch_ff[1] != $past(latch_ff[1])) |=>
        (segment_bias[1:0] == $past(segment_bias[1:0]));
    endproperty
    a_seg_own_bit: assert property (p_seg_own_bit) else $error("segment 1 follows a neighbour");

    property p_snap_capture;
        @(posedge clk) disable iff (!nrst)
        snap_evt |=> (pend_ff && pend_data_ff == $past(latch_ff));
    endproperty
    a_snap_capture: assert property (p_snap_capture) else $error("snapshot not captured");

    property p_overrun;
        @(posedge clk) disable iff (!nrst)
        pend_lost |=> snap_overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule // lcdsd_driver
`default_nettype wire

// [lcdsd_ctrl_model.sv]
// controller model feeding serial segment data, load strobe and frame signal
`timescale 1ns/1ps
`default_nettype none
module lcdsd_ctrl_model (
    input  wire logic clk,
    output var logic  shift_clock,
    output var logic  data_a,
    output var logic  data_b,
    output var logic  latch_strobe,
    output var logic  frame_alternate
);
    initial begin
        shift_clock = 1'b0;
        data_a = 1'b0;
        data_b = 1'b0;
        latch_strobe = 1'b0;
        frame_alternate = 1'b0;
    end
    // one bit per falling shift clock; gap keeps the clock low for slow pacing
    task automatic put_bit(input logic a, input logic b, input int gap);
        @(posedge clk);
        shift_clock <= 1'b1;
        data_a <= a;
        data_b <= b;
        @(posedge clk);
        shift_clock <= 1'b0;
        @(posedge clk);
        // hold time over: lines show the inverse, not the old bit
        data_a <= ~a;
        data_b <= ~b;
        repeat (gap) @(posedge clk);
    endtask
    task automatic set_strobe(input logic s);
        @(posedge clk);
        latch_strobe <= s;
    endtask
    // inversion signal or static common level, held as a level
    task automatic set_frame(input logic f);
        @(posedge clk);
        frame_alternate <= f;
    endtask
endmodule // lcdsd_ctrl_model
`default_nettype wire

// [lcdsd_driver_tb.sv]
// self-checking bench for the lcd segment driver
`timescale 1ns/1ps
`default_nettype none
module lcdsd_driver_tb
    import lcdsd_pkg::*;
();
    logic        clk, nrst, ce, snap_ready, chain_mode;
    logic        sck, din_a, din_b, strobe, frame;
    logic        chain_mid, chain_end, snap_valid, snap_overrun;
    logic [79:0] seg_bias;
    logic [39:0] snap_data, lat;
    logic [19:0] ref_a, ref_b;
    int          bad_count, compares;
    wire logic   sin_b = chain_mode ? chain_mid : din_b;

    lcdsd_ctrl_model ctrl (.clk(clk), .shift_clock(sck), .data_a(din_a), .data_b(din_b),
        .latch_strobe(strobe), .frame_alternate(frame));
    lcdsd_driver DUT (.clk(clk), .nrst(nrst), .ce(ce), .shift_clock(sck),
        .serial_in_first_half(din_a), .serial_in_second_half(sin_b), .latch_strobe(strobe),
        .frame_alternate(frame), .chain_mid_out(chain_mid), .chain_end_out(chain_end),
        .segment_bias(seg_bias), .snap_valid(snap_valid), .snap_ready(snap_ready),
        .snap_data(snap_data), .snap_overrun(snap_overrun));

    task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [79:0] bias_of(input logic [39:0] w, input logic f);
        logic [79:0] e;
        for (int i = 0; i < 40; i++) begin
            e[2*i+:2] = w[i] ? (f ? LCDSD_BIAS_LOWEST : LCDSD_BIAS_TOP)
                             : (f ? LCDSD_BIAS_ONE_THIRD : LCDSD_BIAS_TWO_THIRDS);
        end
        return e;
    endfunction
    // one shift; in chain mode the second half is fed from the middle output
    task automatic sh(input logic a, input logic b, input int gap);
        logic bb;
        bb = chain_mode ? ref_a[0] : b;
        ctrl.put_bit(a, b, gap);
        ref_a = {a, ref_a[19:1]};
        ref_b = {bb, ref_b[19:1]};
        #1;
        chk("chain_mid_out", ref_a[0], chain_mid);
        chk("chain_end_out", ref_b[0], chain_end);
    endtask
    task automatic pop_check(input logic [39:0] exp);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (snap_valid === 1'b1 && snap_ready === 1'b1) break;
        end
        chk("snap_valid", 1'b1, n < 20);
        chk("snap_data", exp, snap_data);
    endtask
    task automatic bias_check();
        for (int f = 1; f >= 0; f--) begin
            ctrl.set_frame(f[0]);
            repeat (3) @(posedge clk);
            #1;
            chk("segment_bias", bias_of(lat, f[0]), seg_bias);
        end
    endtask
    task automatic load_check();
        ctrl.set_strobe(1'b1);
        ctrl.set_strobe(1'b0);
        lat = {ref_b, ref_a};
        pop_check(lat);
        bias_check();
    endtask
    task automatic t_transparent();
        ctrl.set_strobe(1'b1);
        sh(1'b1, 1'b0, 0);
        sh(1'b0, 1'b1, 0);
        lat = {ref_b, ref_a};
        repeat (3) @(posedge clk);
        #1;
        chk("segment_bias", bias_of(lat, frame), seg_bias);
        ctrl.set_strobe(1'b0);
        pop_check(lat);
        sh(1'b1, 1'b1, 0);
        sh(1'b0, 1'b0, 0);
        bias_check();
    endtask
    // clock enable low: shift and strobe activity must leave no trace
    task automatic t_ce();
        @(posedge clk);
        ce <= 1'b0;
        ctrl.put_bit(~ref_a[19], ~ref_b[19], 0);
        ctrl.set_strobe(1'b1);
        ctrl.set_strobe(1'b0);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        chk("chain_mid_out", ref_a[0], chain_mid);
        chk("chain_end_out", ref_b[0], chain_end);
        bias_check();
    endtask
    // second reset in mid-run: sticky flag, chains and stream must clear
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        ref_a = 20'h00000;
        ref_b = 20'h00000;
        lat = 40'h00_0000_0000;
        repeat (2) @(posedge clk);
        #1;
        chk("snap_overrun", 1'b0, snap_overrun);
        chk("snap_valid", 1'b0, snap_valid);
        chk("segment_bias", bias_of(lat, frame), seg_bias);
        sh(1'b1, 1'b1, 0);
    endtask
    task automatic t_buffer();
        logic [39:0] q [$];
        @(posedge clk);
        snap_ready <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            sh(i[0], ~i[0], 0);
            ctrl.set_strobe(1'b1);
            ctrl.set_strobe(1'b0);
            lat = {ref_b, ref_a};
            if (i == 3) q[2] = lat;
            else q.push_back(lat);
            repeat (4) @(posedge clk);
        end
        #1;
        chk("snap_overrun", 1'b1, snap_overrun);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            snap_ready <= 1'b1;
            pop_check(q[k]);
            snap_ready <= 1'b0;
            repeat (3) @(posedge clk);
        end
        #1;
        chk("snap_valid", 1'b0, snap_valid);
        @(posedge clk);
        snap_ready <= 1'b1;
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end
    initial begin
        logic [19:0] pa, pb;
        logic [39:0] pw;
        pa = 20'hA5C3E;
        pb = 20'h3F061;
        pw = 40'hC3_5A96_0F1E;
        nrst = 1'b0;
        ce = 1'b1;
        snap_ready = 1'b1;
        chain_mode = 1'b0;
        bad_count = 0;
        compares = 0;
        ref_a = 20'h00000;
        ref_b = 20'h00000;
        lat = 40'h00_0000_0000;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("segment_bias", bias_of(lat, 1'b0), seg_bias);
        chk("snap_valid", 1'b0, snap_valid);
        for (int i = 0; i < 20; i++) sh(pa[i], pb[i], 0);
        bias_check();
        load_check();
        @(posedge clk);
        chain_mode <= 1'b1;
        for (int i = 0; i < 40; i++) sh(pw[i], 1'b0, 1);
        load_check();
        @(posedge clk);
        chain_mode <= 1'b0;
        t_transparent();
        t_ce();
        t_buffer();
        t_reset();
        end_of_test();
    end
endmodule // lcdsd_driver_tb
`default_nettype wire
